// >>> hdl/cpcr_defs.svh
// Register offsets, reset values and field layout of the converter config bank
`ifndef CPCR_DEFS_SVH
`define CPCR_DEFS_SVH

`define CPCR_NREG 8
`define CPCR_AW 8
`define CPCR_DW 8

// Byte offsets as seen over the serial bus
`define CPCR_OFF_INPUT_PROT 8'h06
`define CPCR_OFF_OC_PRIMARY 8'h07
`define CPCR_OFF_OC_SECONDARY 8'h08
`define CPCR_OFF_OUT_OV 8'h09
`define CPCR_OFF_SOFT_START 8'h0A
`define CPCR_OFF_EN_PIN 8'h0B
`define CPCR_OFF_DEBOUNCE 8'h0C
`define CPCR_OFF_SERIAL 8'h14

// Reset values
`define CPCR_RST_INPUT_PROT 8'h00
`define CPCR_RST_OC_PRIMARY 8'h97
`define CPCR_RST_OC_SECONDARY 8'h0D
`define CPCR_RST_OUT_OV 8'h12
`define CPCR_RST_SOFT_START 8'h31
`define CPCR_RST_EN_PIN 8'h82
`define CPCR_RST_DEBOUNCE 8'h26
`define CPCR_RST_SERIAL 8'h00

// Masks of storage bits; everything else is reserved and reads zero
`define CPCR_MSK_INPUT_PROT 8'h33
`define CPCR_MSK_OC_PRIMARY 8'h9F
`define CPCR_MSK_OC_SECONDARY 8'h0F
`define CPCR_MSK_OUT_OV 8'h1F
`define CPCR_MSK_SOFT_START 8'h37
`define CPCR_MSK_EN_PIN 8'h87
`define CPCR_MSK_DEBOUNCE 8'hB7
`define CPCR_MSK_SERIAL 8'h11

// Field positions
`define CPCR_F_IOV_HI 5
`define CPCR_F_IOV_LO 4
`define CPCR_F_UVF_HI 1
`define CPCR_F_UVF_LO 0
`define CPCR_F_ALARM 7
`define CPCR_F_LIM1_HI 4
`define CPCR_F_LIM1_LO 0
`define CPCR_F_LIM2_HI 3
`define CPCR_F_LIM2_LO 0
`define CPCR_F_OOV_HI 4
`define CPCR_F_OOV_LO 0
`define CPCR_F_SSI_HI 5
`define CPCR_F_SSI_LO 4
`define CPCR_F_SST_HI 2
`define CPCR_F_SST_LO 0
`define CPCR_F_PULLDN 7
`define CPCR_F_ENF_HI 2
`define CPCR_F_ENF_LO 0
`define CPCR_F_WZ 7
`define CPCR_F_UVD_HI 5
`define CPCR_F_UVD_LO 4
`define CPCR_F_OFF_HI 2
`define CPCR_F_OFF_LO 0
`define CPCR_F_MBW 4
`define CPCR_F_HSX 0

// Serial framing
`define CPCR_BITS_PER_BYTE 4'h8
`define CPCR_CNT_ZERO 4'h0
`define CPCR_CNT_ONE 4'h1

`endif

// >>> hdl/cpcr_pkg.sv
// Types shared by the converter config bank files
`default_nettype none
package cpcr_pkg;

  // Serial slave states, Gray steps along the usual write path
  typedef enum logic [3:0] {
    CPCR_IDLE = 4'h0,
    CPCR_ADDR = 4'h1,
    CPCR_ADDR_ACK = 4'h3,
    CPCR_PTR = 4'h2,
    CPCR_PTR_ACK = 4'h6,
    CPCR_WDATA = 4'h7,
    CPCR_WDATA_ACK = 4'h5,
    CPCR_RDATA = 4'h4,
    CPCR_RDATA_ACK = 4'hC
  } cpcr_state_t;

  // Settings handed to the analog converter
  typedef struct packed {
    logic [1:0] input_overvoltage_level;
    logic [1:0] input_undervoltage_falling_level;
    logic current_alarm_ratio;
    logic [4:0] current_limit_primary;
    logic [3:0] current_limit_secondary;
    logic [4:0] output_overvoltage_level;
    logic [1:0] soft_start_current;
    logic [2:0] soft_start_timeout;
    logic enable_pin_pulldown_on;
    logic [2:0] enable_pin_filter_time;
    logic must_write_zero_bit;
    logic [1:0] undervoltage_filter_time;
    logic [2:0] off_filter_time;
    logic multi_byte_write_select;
    logic high_speed_extension_on;
  } cpcr_cfg_t;

  // Serial data pin as two signals
  typedef struct packed {
    logic out;
    logic oe;
  } cpcr_pin_t;

endpackage
`default_nettype wire

// >>> hdl/cpcr_reg.sv
// One byte-wide configuration register with reset value and reserved mask
`timescale 1ns/100ps
`default_nettype none
module cpcr_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] MASK = 8'hFF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] q
);

  logic [7:0] val_q;
  logic [7:0] val_d;

  // Reserved bits never store, so they always read zero
  assign val_d = wr_en ? (wr_data & MASK) : val_q;
  assign q = val_q;

  // Reset value loads on device reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      val_q <= RESET_VAL & MASK;
    end else begin
      val_q <= val_d;
    end
  end

endmodule
`default_nettype wire

// >>> hdl/cpcr_top.sv
// Converter protection config bank behind a two-wire serial slave
`timescale 1ns/100ps
`default_nettype none
`include "cpcr_defs.svh"
module cpcr_top #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output cpcr_pkg::cpcr_cfg_t cfg
);

  // Offsets and reset values of the bank, one entry per register
  localparam logic [7:0] OFFS [`CPCR_NREG] = '{
    `CPCR_OFF_INPUT_PROT, `CPCR_OFF_OC_PRIMARY, `CPCR_OFF_OC_SECONDARY,
    `CPCR_OFF_OUT_OV, `CPCR_OFF_SOFT_START, `CPCR_OFF_EN_PIN,
    `CPCR_OFF_DEBOUNCE, `CPCR_OFF_SERIAL};
  localparam logic [7:0] RSTS [`CPCR_NREG] = '{
    `CPCR_RST_INPUT_PROT, `CPCR_RST_OC_PRIMARY, `CPCR_RST_OC_SECONDARY,
    `CPCR_RST_OUT_OV, `CPCR_RST_SOFT_START, `CPCR_RST_EN_PIN,
    `CPCR_RST_DEBOUNCE, `CPCR_RST_SERIAL};
  localparam logic [7:0] MSKS [`CPCR_NREG] = '{
    `CPCR_MSK_INPUT_PROT, `CPCR_MSK_OC_PRIMARY, `CPCR_MSK_OC_SECONDARY,
    `CPCR_MSK_OUT_OV, `CPCR_MSK_SOFT_START, `CPCR_MSK_EN_PIN,
    `CPCR_MSK_DEBOUNCE, `CPCR_MSK_SERIAL};

  // Pin synchronisers and edge history
  logic scl_m_q;
  logic scl_s_q;
  logic scl_p_q;
  logic sda_m_q;
  logic sda_s_q;
  logic sda_p_q;

  // Slave state
  cpcr_pkg::cpcr_state_t state_q;
  cpcr_pkg::cpcr_state_t state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic rw_q;
  logic rw_d;
  logic nack_q;
  logic nack_d;
  logic drive_q;
  logic drive_d;

  // Register file wires
  logic [7:0] regs [`CPCR_NREG];
  logic [`CPCR_NREG-1:0] wr_sel;
  logic [7:0] rd_data;
  logic wr_stb;

  // Two flops on each pin before any logic looks at it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Idle-high levels, so no false edge follows reset
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
    end
  end

  // Previous synchronised levels for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s_q;
      sda_p_q <= sda_s_q;
    end
  end

  // Bus events; start and stop are data moves while the clock is high
  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire bus_stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire byte_done = (cnt_q == `CPCR_BITS_PER_BYTE);
  wire addr_hit = (shift_q[7:1] == DEV_ADDR);
  wire recv_state = (state_q == cpcr_pkg::CPCR_ADDR) |
                    (state_q == cpcr_pkg::CPCR_PTR) |
                    (state_q == cpcr_pkg::CPCR_WDATA);

  // Next pointer and first read bit, shared by several states
  wire [7:0] ptr_inc = ptr_q + 8'h01;
  wire [7:0] tx_load = {rd_data[6:0], 1'b0};
  wire tx_first_low = ~rd_data[7];

  // Write strobe fires on the falling edge that ends a data byte
  assign wr_stb = (state_q == cpcr_pkg::CPCR_WDATA) & scl_fall & byte_done;

  // Registers; the bank lives here, one instance per offset
  genvar gi;
  generate
    for (gi = 0; gi < `CPCR_NREG; gi++) begin : g_reg
      // An unmapped pointer strobes nothing, so the byte is dropped
      assign wr_sel[gi] = wr_stb & (ptr_q == OFFS[gi]);
      cpcr_reg #(
        .RESET_VAL(RSTS[gi]),
        .MASK(MSKS[gi])
      ) u_reg (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(wr_sel[gi]),
        .wr_data(shift_q),
        .q(regs[gi])
      );
    end
  endgenerate

  // Read mux; an unmapped offset reads zero
  always_comb begin
    rd_data = 8'h00;
    for (int i = 0; i < `CPCR_NREG; i++) begin
      if (ptr_q == OFFS[i]) begin
        rd_data = regs[i];
      end
    end
  end

  // Slave sequencing, bit shifting and acknowledge drive
  always_comb begin
    // Hold everything unless an event below moves it
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    tx_d = tx_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    nack_d = nack_q;
    drive_d = drive_q;
    if (bus_start) begin
      // Repeated start restarts addressing and keeps the pointer
      state_d = cpcr_pkg::CPCR_ADDR;
      cnt_d = `CPCR_CNT_ZERO;
      drive_d = 1'b0;
    end else if (bus_stop) begin
      state_d = cpcr_pkg::CPCR_IDLE;
      drive_d = 1'b0;
    end else begin
      // Receive states shift in on the clock rise
      if (scl_rise && recv_state) begin
        shift_d = {shift_q[6:0], sda_s_q};
        cnt_d = cnt_q + `CPCR_CNT_ONE;
      end
      // Host answer to a read byte, taken at the clock rise
      if (scl_rise && state_q == cpcr_pkg::CPCR_RDATA_ACK) begin
        nack_d = sda_s_q;
      end
      unique case (state_q)
        // Line released, waiting for a start
        cpcr_pkg::CPCR_IDLE: begin
          drive_d = 1'b0;
        end
        // Address byte; a miss stays out until the next start
        cpcr_pkg::CPCR_ADDR: begin
          if (scl_fall && byte_done) begin
            cnt_d = `CPCR_CNT_ZERO;
            if (addr_hit) begin
              rw_d = shift_q[0];
              drive_d = 1'b1;
              state_d = cpcr_pkg::CPCR_ADDR_ACK;
            end else begin
              state_d = cpcr_pkg::CPCR_IDLE;
            end
          end
        end
        // Address acknowledge; a read sends its first bit at its end
        cpcr_pkg::CPCR_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              // Read starts at the current pointer; first bit goes out now
              tx_d = tx_load;
              drive_d = tx_first_low;
              cnt_d = `CPCR_CNT_ONE;
              state_d = cpcr_pkg::CPCR_RDATA;
            end else begin
              drive_d = 1'b0;
              state_d = cpcr_pkg::CPCR_PTR;
            end
          end
        end
        // Pointer byte; always acknowledged, mapped or not
        cpcr_pkg::CPCR_PTR: begin
          if (scl_fall && byte_done) begin
            ptr_d = shift_q;
            cnt_d = `CPCR_CNT_ZERO;
            drive_d = 1'b1;
            state_d = cpcr_pkg::CPCR_PTR_ACK;
          end
        end
        // Pointer acknowledge; data bytes follow
        cpcr_pkg::CPCR_PTR_ACK: begin
          if (scl_fall) begin
            drive_d = 1'b0;
            state_d = cpcr_pkg::CPCR_WDATA;
          end
        end
        cpcr_pkg::CPCR_WDATA: begin
          if (scl_fall && byte_done) begin
            // Written this edge; pointer steps for the next byte
            ptr_d = ptr_inc;
            cnt_d = `CPCR_CNT_ZERO;
            drive_d = 1'b1;
            state_d = cpcr_pkg::CPCR_WDATA_ACK;
          end
        end
        // Data acknowledge; another byte may follow
        cpcr_pkg::CPCR_WDATA_ACK: begin
          if (scl_fall) begin
            drive_d = 1'b0;
            state_d = cpcr_pkg::CPCR_WDATA;
          end
        end
        // Read byte, one bit per clock fall, most significant first
        cpcr_pkg::CPCR_RDATA: begin
          if (scl_fall) begin
            if (byte_done) begin
              // Release the line so the host can answer
              drive_d = 1'b0;
              ptr_d = ptr_inc;
              state_d = cpcr_pkg::CPCR_RDATA_ACK;
            end else begin
              drive_d = ~tx_q[7];
              tx_d = {tx_q[6:0], 1'b0};
              cnt_d = cnt_q + `CPCR_CNT_ONE;
            end
          end
        end
        // A refusal ends the read, an acknowledge loads the next byte
        cpcr_pkg::CPCR_RDATA_ACK: begin
          if (scl_fall) begin
            if (nack_q) begin
              state_d = cpcr_pkg::CPCR_IDLE;
            end else begin
              tx_d = tx_load;
              drive_d = tx_first_low;
              cnt_d = `CPCR_CNT_ONE;
              state_d = cpcr_pkg::CPCR_RDATA;
            end
          end
        end
        // Unused codes fall back to idle with the line released
        default: begin
          state_d = cpcr_pkg::CPCR_IDLE;
          drive_d = 1'b0;
        end
      endcase
    end
  end

  // Slave flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= cpcr_pkg::CPCR_IDLE;
      cnt_q <= `CPCR_CNT_ZERO;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      drive_q <= drive_d;
    end
  end

  // Open-drain data pin: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = drive_q;

  // Field taps toward the converter: input protection selectors
  assign cfg.input_overvoltage_level = regs[0][`CPCR_F_IOV_HI:`CPCR_F_IOV_LO];
  assign cfg.input_undervoltage_falling_level =
    regs[0][`CPCR_F_UVF_HI:`CPCR_F_UVF_LO];

  // Primary overcurrent: alarm ratio and layer-one limit
  assign cfg.current_alarm_ratio = regs[1][`CPCR_F_ALARM];
  assign cfg.current_limit_primary = regs[1][`CPCR_F_LIM1_HI:`CPCR_F_LIM1_LO];

  // All-ones code turns the second layer off in the converter
  assign cfg.current_limit_secondary = regs[2][`CPCR_F_LIM2_HI:`CPCR_F_LIM2_LO];

  // Output overvoltage rising threshold code
  assign cfg.output_overvoltage_level = regs[3][`CPCR_F_OOV_HI:`CPCR_F_OOV_LO];

  // Soft-start current and timeout codes
  assign cfg.soft_start_current = regs[4][`CPCR_F_SSI_HI:`CPCR_F_SSI_LO];
  assign cfg.soft_start_timeout = regs[4][`CPCR_F_SST_HI:`CPCR_F_SST_LO];

  // Enable pin pulldown and its filter time
  assign cfg.enable_pin_pulldown_on = regs[5][`CPCR_F_PULLDN];
  assign cfg.enable_pin_filter_time = regs[5][`CPCR_F_ENF_HI:`CPCR_F_ENF_LO];

  // Stored as written; the host is expected to keep it zero
  assign cfg.must_write_zero_bit = regs[6][`CPCR_F_WZ];
  assign cfg.undervoltage_filter_time = regs[6][`CPCR_F_UVD_HI:`CPCR_F_UVD_LO];
  assign cfg.off_filter_time = regs[6][`CPCR_F_OFF_HI:`CPCR_F_OFF_LO];

  // Write mode is stored only; the slave steps the pointer in both modes
  assign cfg.multi_byte_write_select = regs[7][`CPCR_F_MBW];
  assign cfg.high_speed_extension_on = regs[7][`CPCR_F_HSX];

endmodule
`default_nettype wire

// >>> dv/cpcr_props.sv
// Port checker for the converter config bank
`timescale 1ns/100ps
`default_nettype none
module cpcr_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire cpcr_pkg::cpcr_cfg_t cfg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Reset values as seen on the first edge after every release
  property p_uvf_rst;
    $rose(rst_n) |-> cfg.input_undervoltage_falling_level == 2'h0;
  endproperty
  a_uvf_rst: assert property (p_uvf_rst) else $error("undervoltage level reset wrong");
  property p_alarm_rst;
    $rose(rst_n) |-> cfg.current_alarm_ratio == 1'b1;
  endproperty
  a_alarm_rst: assert property (p_alarm_rst) else $error("alarm ratio reset wrong");
  property p_lim1_rst;
    $rose(rst_n) |-> cfg.current_limit_primary == 5'h17;
  endproperty
  a_lim1_rst: assert property (p_lim1_rst) else $error("primary limit reset wrong");
  property p_lim2_rst;
    $rose(rst_n) |-> cfg.current_limit_secondary == 4'hD;
  endproperty
  a_lim2_rst: assert property (p_lim2_rst) else $error("secondary limit reset wrong");
  property p_oov_rst;
    $rose(rst_n) |-> cfg.output_overvoltage_level == 5'h12;
  endproperty
  a_oov_rst: assert property (p_oov_rst) else $error("overvoltage reset wrong");
  property p_ss_rst;
    $rose(rst_n) |-> {cfg.soft_start_current, cfg.soft_start_timeout} == 5'h19;
  endproperty
  a_ss_rst: assert property (p_ss_rst) else $error("soft-start reset wrong");
  property p_en_rst;
    $rose(rst_n) |-> {cfg.enable_pin_pulldown_on, cfg.enable_pin_filter_time} == 4'hA;
  endproperty
  a_en_rst: assert property (p_en_rst) else $error("enable pin reset wrong");
  property p_deb_rst;
    $rose(rst_n) |-> {cfg.undervoltage_filter_time, cfg.off_filter_time} == 5'h16;
  endproperty
  a_deb_rst: assert property (p_deb_rst) else $error("filter reset wrong");
  property p_ser_rst;
    $rose(rst_n) |-> {cfg.multi_byte_write_select, cfg.high_speed_extension_on} == 2'h0;
  endproperty
  a_ser_rst: assert property (p_ser_rst) else $error("serial cfg reset wrong");
  // Settings only move after a byte ends, so never while the clock pin is high
  property p_cfg_quiet;
    $changed(cfg) |-> !scl_in;
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet) else $error("settings moved mid-bit");
  // Open drain: the driven level of the data pin is always low
  property p_sda_low;
    sda_out == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("data pin driven high");
  // The slave only takes the data line while the clock pin is low
  property p_oe_rise_low;
    $rose(sda_oe) |-> !scl_in;
  endproperty
  a_oe_rise_low: assert property (p_oe_rise_low) else $error("line taken mid-bit");
endmodule
bind cpcr_top cpcr_props cpcr_props_inst (.clk(clk), .rst_n(rst_n), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .cfg(cfg));
`default_nettype wire

// >>> dv/cpcr_host.sv
// Two-wire bus host model that reads and writes the config bank
`timescale 1ns/100ps
`default_nettype none
module cpcr_host #(
  parameter logic [6:0] DEV = 7'h2A // Arbitrary value
) (
  input wire logic clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic drv_q = 1'b1;
  // Open-drain wire with pull-up: released means high
  assign sda = drv_q & ~sda_oe;
  initial scl = 1'b1;

  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One bit: data moves mid-low, sampled mid-high, 8 clocks per phase
  task automatic bit_x(input logic b, output logic r);
    hold(4);
    drv_q = b;
    hold(4);
    scl = 1'b1;
    hold(4);
    r = sda;
    hold(4);
    scl = 1'b0;
  endtask

  // Start or repeated start; clock stays still outside frames
  task automatic start();
    hold(4);
    drv_q = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(8);
    drv_q = 1'b0;
    hold(8);
    scl = 1'b0;
  endtask

  task automatic stop();
    hold(4);
    drv_q = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(8);
    drv_q = 1'b1;
    hold(8);
  endtask

  // Eight bits MSB first, then the acknowledge slot
  task automatic byte_x(input logic [7:0] d, output logic [7:0] r, output logic ak);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(1'b1, b);
    ak = ~b;
  endtask

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d,
                           output logic ok);
    logic [7:0] r;
    logic a0;
    logic a1;
    logic a2;
    start();
    byte_x({dev, 1'b0}, r, a0);
    byte_x(p, r, a1);
    byte_x((p == 8'h0C) ? (d & 8'h7F) : d, r, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask

  // Two data bytes in one frame; the pointer steps between them
  task automatic write_pair(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1,
                            output logic ok);
    logic [7:0] r;
    logic a0;
    logic a1;
    logic a2;
    logic a3;
    start();
    byte_x({DEV, 1'b0}, r, a0);
    byte_x(p, r, a1);
    byte_x(d0, r, a2);
    byte_x(d1, r, a3);
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask

  // Two bytes read in one frame: first acknowledged, second refused
  task automatic read_pair(input logic [7:0] p, output logic [7:0] v0, output logic [7:0] v1,
                           output logic ok);
    logic [7:0] r;
    logic a0;
    logic a1;
    logic a2;
    logic a3;
    logic b;
    start();
    byte_x({DEV, 1'b0}, r, a0);
    byte_x(p, r, a1);
    start();
    byte_x({DEV, 1'b1}, r, a2);
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, v0[i]);
    end
    bit_x(1'b0, b);
    byte_x(8'hFF, v1, a3);
    stop();
    ok = a0 & a1 & a2;
  endtask

  // Pointer write, repeated start, one byte read and refused with a nack
  task automatic read_reg(input logic [7:0] p, output logic [7:0] v, output logic ok);
    logic [7:0] r;
    logic a0;
    logic a1;
    logic a2;
    logic a3;
    start();
    byte_x({DEV, 1'b0}, r, a0);
    byte_x(p, r, a1);
    start();
    byte_x({DEV, 1'b1}, r, a2);
    byte_x(8'hFF, v, a3);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

// >>> dv/converter_protection_config_regs_test.sv
// Self-checking bench for the converter config bank
`timescale 1ns/100ps
`default_nettype none
module converter_protection_config_regs_test;
  localparam logic [6:0] DEV_OK = 7'h2A; // Arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl;
  logic sda;
  logic sda_oe;
  cpcr_pkg::cpcr_cfg_t cfg;
  int miscompares = 0;
  int total_checks = 0;
  logic [7:0] offs [8] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h14};
  logic [7:0] rstv [8] = '{8'h00, 8'h97, 8'h0D, 8'h12, 8'h31, 8'h82, 8'h26, 8'h00};
  // Stored bits; the must-write-zero bit is left out since the host never sets it
  logic [7:0] msk [8] = '{8'h33, 8'h9F, 8'h0F, 8'h1F, 8'h37, 8'h87, 8'h37, 8'h11};
  logic [7:0] pats [4] = '{8'hFF, 8'h55, 8'hAA, 8'h00};
  logic [7:0] img [8];
  logic [7:0] v;
  logic [7:0] v1;
  logic ok;

  initial forever #4 clk = ~clk;

  cpcr_top #(.DEV_ADDR(DEV_OK)) cpcr_top_inst (.clk(clk), .rst_n(rst_n), .scl_in(scl),
    .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .cfg(cfg));
  cpcr_host #(.DEV(DEV_OK)) cpcr_host_inst (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Field taps expected from the register image
  function automatic cpcr_pkg::cpcr_cfg_t expect_cfg();
    return {img[0][5:4], img[0][1:0], img[1][7], img[1][4:0], img[2][3:0], img[3][4:0],
      img[4][5:4], img[4][2:0], img[5][7], img[5][2:0], img[6][7], img[6][5:4],
      img[6][2:0], img[7][4], img[7][0]};
  endfunction

  // Read every register back and compare the exported settings
  task automatic verify_all();
    for (int i = 0; i < 8; i++) begin
      cpcr_host_inst.read_reg(offs[i], v, ok);
      check(64'(ok), 64'h1, "read ack");
      check(64'(v), 64'(img[i]), "read value");
    end
    check(64'(cfg), 64'(expect_cfg()), "field taps");
    check(64'(cfg), 64'(expect_cfg()), "timing taps");
    check(64'(cfg), 64'(expect_cfg()), "mode taps");
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    img = rstv;
  endtask

  // Hang guard: a stuck run ends through the normal verdict
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    give_verdict();
  end

  initial begin
    do_reset();
    verify_all();
    // All-ones first so reserved bits are hammered; all-zero last
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 8; i++) begin
        cpcr_host_inst.write_reg(DEV_OK, offs[i], pats[p], ok);
        check(64'(ok), 64'h1, "write ack");
        img[i] = pats[p] & msk[i];
      end
      verify_all();
    end
    // Unmapped offset is acknowledged, dropped and reads zero
    cpcr_host_inst.write_reg(DEV_OK, 8'h10, 8'hFF, ok);
    check(64'(ok), 64'h1, "unmapped write ack");
    cpcr_host_inst.read_reg(8'h10, v, ok);
    check(64'(v), 64'h0, "unmapped read");
    // Two-byte frames: the pointer steps after each byte both ways
    cpcr_host_inst.write_pair(8'h09, 8'hF5, 8'hFA, ok);
    check(64'(ok), 64'h1, "pair write ack");
    img[3] = 8'hF5 & msk[3];
    img[4] = 8'hFA & msk[4];
    cpcr_host_inst.read_pair(8'h09, v, v1, ok);
    check(64'(ok), 64'h1, "pair read ack");
    check(64'(v), 64'(img[3]), "pair read first");
    check(64'(v1), 64'(img[4]), "pair read second");
    // Foreign device address must not touch anything
    cpcr_host_inst.write_reg(7'h2B, 8'h07, 8'hFF, ok);
    check(64'(ok), 64'h0, "foreign address");
    verify_all();
    // Second reset in mid-run restores every reset value
    do_reset();
    verify_all();
    give_verdict();
  end
endmodule
`default_nettype wire
